// >>> verilog/ies_pkg.sv
// Constants, types and register map of the infeed enable sequencer.
package ies_pkg;

  // Clock period and the one millisecond spread delay.
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_MS_NS = 1000000;
  localparam int MS_CYC = (T_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_W = 18;

  // Sequence times in milliseconds, counted on the millisecond tick.
  localparam logic [15:0] SWAP_MS = 16'h01f4;
  localparam logic [15:0] ENABLE_MS = 16'h03e8;

  // Register byte offsets.
  localparam logic [7:0] OFS_SPD_THR = 8'h00;
  localparam logic [7:0] OFS_BRK_TIME = 8'h04;
  localparam logic [7:0] OFS_DROPOUT = 8'h08;
  localparam logic [7:0] OFS_DECEL = 8'h0c;
  localparam logic [7:0] OFS_REGEN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Register values after reset.
  localparam logic [15:0] RST_SPD_THR = 16'h0010;
  localparam logic [15:0] RST_BRK_TIME = 16'h01f4;
  localparam logic [15:0] RST_DROPOUT = 16'h0064;
  localparam logic [15:0] RST_DECEL = 16'h0100;
  localparam logic [15:0] RST_REGEN = 16'h0100;

  // Status register bit positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PRECHG = 4;
  localparam int ST_LINE = 5;
  localparam int ST_INTEN = 6;
  localparam int ST_PULSE = 7;
  localparam int ST_DRIVE = 8;
  localparam int ST_BRAKE = 9;
  localparam int ST_ISOL = 10;

  // Power sequence states.
  typedef enum logic [2:0] {
    IES_IDLE,
    IES_PRECHARGE,
    IES_CHARGED,
    IES_RUN,
    IES_SHUT_PULSE,
    IES_SHUT_CONTACT
  } ies_state_t;

  // Software settings that steer braking and the contactor drop-out.
  typedef struct packed {
    logic [15:0] spd_thr;
    logic [15:0] brk_time;
    logic [15:0] dropout;
    logic [15:0] decel_lim;
    logic [15:0] regen_lim;
  } ies_cfg_t;

  // Delayed copies of the three enable terminals.
  typedef struct packed {
    logic start;
    logic pulse;
    logic drive;
  } ies_en_t;

endpackage

// >>> verilog/ies_delay.sv
// Level delay line that passes a change once it has held for a set time.
`timescale 1ns/100ps
module ies_delay
  import ies_pkg::*;
#(
  parameter int P_DLY = MS_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and delayed level out.
  input wire logic d_i,
  output logic q_o
);

  logic [CYC_W-1:0] cnt_reg; // Cycles the input has differed.
  logic q_reg; // Delayed level.

  // A short glitch restarts the count, so only a held change passes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      q_reg <= 1'b0;
    end else if (d_i == q_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CYC_W'(P_DLY - 1)) begin
      cnt_reg <= '0;
      q_reg <= d_i;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign q_o = q_reg;

endmodule

// >>> verilog/ies_top.sv
// Power-on, shutdown and enable spreading of an infeed module.
`timescale 1ns/100ps
module ies_top
  import ies_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Enable terminals from the machine controller.
  input wire logic START_I,
  input wire logic PULSE_EN_I,
  input wire logic DRIVE_EN_I,
  // Power stage feedback.
  input wire logic DC_CHARGED_I,
  input wire logic CONTACTOR_COIL_LOOP_CLOSED_I,
  input wire logic [15:0] SPEED_I,
  // Register port.
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // Contactors and infeed enables.
  output logic PRECHG_CONTACTOR_O,
  output logic LINE_CONTACTOR_O,
  output logic INT_ENABLE_O,
  output logic INFEED_PULSE_EN_O,
  output logic DCLINK_REGULATED_O,
  // Drive group enables and braking.
  output logic MODULE_PULSE_EN_O,
  output logic DRIVE_PULSE_EN_O,
  output logic DRIVE_ENABLE_O,
  output logic SPEED_SET_ZERO_O,
  output logic [15:0] DECEL_LIMIT_O,
  output logic [15:0] REGEN_LIMIT_O
);

  //////////////////////////////////////////////////////////////////////////
  // Millisecond timebase and delayed terminals.
  //////////////////////////////////////////////////////////////////////////

  logic [CYC_W-1:0] cyc_cnt_reg; // Cycles within the current millisecond.
  logic ms_tick; // One-cycle pulse each millisecond.
  ies_en_t en_dly; // Terminals after the 1 ms spread delay.

  // Free-running timebase; sequence times are therefore exact to one tick.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      cyc_cnt_reg <= '0;
    end else if (ms_tick) begin
      cyc_cnt_reg <= '0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
    end
  end

  assign ms_tick = (cyc_cnt_reg == CYC_W'(P_MS_CYCLES - 1));

  // Start delay: pulses fall about 1 ms after start is withdrawn.
  ies_delay #(.P_DLY(P_MS_CYCLES)) u_start_dly (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(START_I),
    .q_o(en_dly.start)
  );

  // Pulse enable delay, shared by every module of the group.
  ies_delay #(.P_DLY(P_MS_CYCLES)) u_pulse_dly (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(PULSE_EN_I),
    .q_o(en_dly.pulse)
  );

  // Drive enable delay, shared by every drive.
  ies_delay #(.P_DLY(P_MS_CYCLES)) u_drive_dly (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(DRIVE_EN_I),
    .q_o(en_dly.drive)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register file.
  //////////////////////////////////////////////////////////////////////////

  ies_cfg_t cfg_reg; // Software settings.
  logic [31:0] rdata_reg; // Read data, valid one cycle after the strobe.
  logic [31:0] status; // Live status word.
  logic isolated_reg; // Line isolation completed.
  ies_state_t state_reg; // Sequence state.
  ies_state_t state_next; // Next sequence state.
  logic prechg_reg; // Pre-charge contactor command.
  logic line_reg; // Line contactor command.
  logic infeed_pulse_reg; // Infeed pulse enable.
  logic drive_pulse_reg; // Drive pulse enable.
  logic drive_en_reg; // Drive enable.
  logic braking_reg; // Drive-enable braking in progress.

  // Widen a 16-bit setting into a bus word with zero upper bits.
  function automatic logic [31:0] word16(input logic [15:0] v);
    word16 = {16'h0000, v};
  endfunction

  // Write side; the settings take effect on the next edge.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      cfg_reg.spd_thr <= RST_SPD_THR;
      cfg_reg.brk_time <= RST_BRK_TIME;
      cfg_reg.dropout <= RST_DROPOUT;
      cfg_reg.decel_lim <= RST_DECEL;
      cfg_reg.regen_lim <= RST_REGEN;
    end else if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        OFS_SPD_THR: cfg_reg.spd_thr <= REG_WDATA_I[15:0];
        OFS_BRK_TIME: cfg_reg.brk_time <= REG_WDATA_I[15:0];
        OFS_DROPOUT: cfg_reg.dropout <= REG_WDATA_I[15:0];
        OFS_DECEL: cfg_reg.decel_lim <= REG_WDATA_I[15:0];
        OFS_REGEN: cfg_reg.regen_lim <= REG_WDATA_I[15:0];
        // Status and unmapped offsets ignore writes.
        default: begin
        end
      endcase
    end
  end

  // Status gathers state and every power command but the drive pulse enable for software.
  always_comb begin
    status = 32'h0000_0000;
    status[ST_STATE_LSB +: 3] = state_reg;
    status[ST_PRECHG] = prechg_reg;
    status[ST_LINE] = line_reg;
    status[ST_INTEN] = INT_ENABLE_O;
    status[ST_PULSE] = infeed_pulse_reg;
    status[ST_DRIVE] = drive_en_reg;
    status[ST_BRAKE] = braking_reg;
    status[ST_ISOL] = isolated_reg;
  end

  // Read side; data stands for one cycle only, unmapped reads give zero.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        OFS_SPD_THR: rdata_reg <= word16(cfg_reg.spd_thr);
        OFS_BRK_TIME: rdata_reg <= word16(cfg_reg.brk_time);
        OFS_DROPOUT: rdata_reg <= word16(cfg_reg.dropout);
        OFS_DECEL: rdata_reg <= word16(cfg_reg.decel_lim);
        OFS_REGEN: rdata_reg <= word16(cfg_reg.regen_lim);
        OFS_STATUS: rdata_reg <= status;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign REG_RDATA_O = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Power-on and power-off sequence.
  //////////////////////////////////////////////////////////////////////////

  logic [15:0] ms_cnt_reg; // Milliseconds spent in the current state.

  // Next state; start is only looked at where the sequence allows it.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IES_IDLE: begin
        if (START_I) begin
          state_next = IES_PRECHARGE;
        end
      end
      IES_PRECHARGE: begin
        // Start low is ignored here: charging always completes.
        if (DC_CHARGED_I) begin
          state_next = IES_CHARGED;
        end
      end
      IES_CHARGED: begin
        if (!START_I) begin
          state_next = IES_SHUT_PULSE;
        end else if (ms_cnt_reg == ENABLE_MS) begin
          state_next = IES_RUN;
        end
      end
      IES_RUN: begin
        if (!START_I) begin
          state_next = IES_SHUT_PULSE;
        end
      end
      IES_SHUT_PULSE: begin
        // Leave once the delayed start has cut the pulses.
        if (!en_dly.start) begin
          state_next = IES_SHUT_CONTACT;
        end
      end
      IES_SHUT_CONTACT: begin
        if (ms_cnt_reg == cfg_reg.dropout) begin
          state_next = IES_IDLE;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= IES_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Millisecond count, cleared on every state change.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ms_cnt_reg <= 16'h0000;
    end else if (state_next != state_reg) begin
      ms_cnt_reg <= 16'h0000;
    end else if (ms_tick && ms_cnt_reg != 16'hffff) begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  // Contactor commands; the swap is one edge so both never conduct together.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      prechg_reg <= 1'b0;
      line_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        IES_PRECHARGE: begin
          prechg_reg <= 1'b1;
          line_reg <= 1'b0;
        end
        IES_CHARGED: begin
          if (ms_cnt_reg >= SWAP_MS) begin
            prechg_reg <= 1'b0;
            line_reg <= 1'b1;
          end
        end
        IES_RUN: begin
          prechg_reg <= 1'b0;
          line_reg <= 1'b1;
        end
        IES_SHUT_PULSE: begin
          prechg_reg <= 1'b0;
        end
        IES_SHUT_CONTACT: begin
          prechg_reg <= 1'b0;
          line_reg <= 1'b0;
        end
        IES_IDLE: begin
          prechg_reg <= 1'b0;
          line_reg <= 1'b0;
        end
      endcase
    end
  end

  // Isolation is reported once the drop-out time has run out.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      isolated_reg <= 1'b0;
    end else if (state_reg == IES_SHUT_CONTACT && state_next == IES_IDLE) begin
      isolated_reg <= 1'b1;
    end else if (state_reg == IES_PRECHARGE) begin
      isolated_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pulse and drive enables, braking.
  //////////////////////////////////////////////////////////////////////////

  logic int_en; // Internal enables issued.
  logic pulse_on; // Pulses allowed by start and pulse enable.
  logic brake_done; // Braking ends on speed or timer.
  logic drive_dly_q; // Previous delayed drive enable.
  logic [15:0] brk_ms_reg; // Milliseconds spent braking.
  logic int_en_reg; // Registered internal enable.

  assign int_en = (state_reg == IES_RUN) || (state_reg == IES_SHUT_PULSE);
  // Start gates everything, so its inhibit wins over both terminals.
  assign pulse_on = int_en && en_dly.start && en_dly.pulse;
  assign brake_done = (SPEED_I < cfg_reg.spd_thr) ||
                      (brk_ms_reg >= cfg_reg.brk_time);

  // Braking starts on a drive-enable fall while pulses run.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      braking_reg <= 1'b0;
      brk_ms_reg <= 16'h0000;
      drive_dly_q <= 1'b0;
    end else begin
      drive_dly_q <= en_dly.drive;
      if (!pulse_on || en_dly.drive) begin
        // Pulse withdrawal cancels braking: the drives coast.
        braking_reg <= 1'b0;
        brk_ms_reg <= 16'h0000;
      end else if (drive_dly_q && drive_en_reg) begin
        braking_reg <= 1'b1;
        brk_ms_reg <= 16'h0000;
      end else if (braking_reg && brake_done) begin
        braking_reg <= 1'b0;
      end else if (braking_reg && ms_tick) begin
        brk_ms_reg <= brk_ms_reg + 16'h0001;
      end
    end
  end

  // Registered enables; one edge drives every module at once.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      int_en_reg <= 1'b0;
      infeed_pulse_reg <= 1'b0;
      drive_pulse_reg <= 1'b0;
      drive_en_reg <= 1'b0;
    end else begin
      int_en_reg <= int_en;
      infeed_pulse_reg <= pulse_on;
      drive_en_reg <= pulse_on && en_dly.drive;
      // The start-of-braking term bridges the edge before braking_reg rises.
      drive_pulse_reg <= pulse_on &&
                         (en_dly.drive || (braking_reg && !brake_done) ||
                          (drive_dly_q && drive_en_reg));
    end
  end

  // Outputs; the line contactor can only pull in with the coil loop shut.
  assign PRECHG_CONTACTOR_O = prechg_reg;
  assign LINE_CONTACTOR_O = line_reg && CONTACTOR_COIL_LOOP_CLOSED_I;
  assign INT_ENABLE_O = int_en_reg;
  assign INFEED_PULSE_EN_O = infeed_pulse_reg;
  assign MODULE_PULSE_EN_O = infeed_pulse_reg;
  assign DCLINK_REGULATED_O = infeed_pulse_reg;
  assign DRIVE_PULSE_EN_O = drive_pulse_reg;
  assign DRIVE_ENABLE_O = drive_en_reg;
  assign SPEED_SET_ZERO_O = !drive_en_reg;
  assign DECEL_LIMIT_O = cfg_reg.decel_lim;
  assign REGEN_LIMIT_O = cfg_reg.regen_lim;

  //////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_precharge_first: assert property (
    (state_reg == IES_IDLE && START_I) |=> state_reg == IES_PRECHARGE
      ##1 prechg_reg && !line_reg)
    else $error("start did not begin pre-charge");
  a_charge_gate: assert property (
    (state_reg == IES_PRECHARGE ##1 state_reg != IES_PRECHARGE)
      |-> $past(DC_CHARGED_I))
    else $error("pre-charge left without charged detect");
  a_contact_swap: assert property (
    $rose(line_reg) |-> $fell(prechg_reg) && $past(ms_cnt_reg) == SWAP_MS)
    else $error("contactor swap not simultaneous at 500 ms");
  a_enable_time: assert property (
    (state_reg == IES_CHARGED && ms_cnt_reg == ENABLE_MS && START_I)
      |=> state_reg == IES_RUN ##1 int_en_reg)
    else $error("internal enables not issued at 1 s");
  a_shut_pulse: assert property (
    (state_reg == IES_SHUT_PULSE && !en_dly.start)
      |=> !infeed_pulse_reg && state_reg == IES_SHUT_CONTACT)
    else $error("pulses not cut before contactor release");
  a_line_release: assert property (
    $fell(line_reg) |-> !infeed_pulse_reg && !prechg_reg)
    else $error("line contactor released with pulses on");
  a_precharge_hold: assert property (
    (state_reg == IES_PRECHARGE && !START_I && !DC_CHARGED_I)
      |=> state_reg == IES_PRECHARGE && prechg_reg)
    else $error("pre-charge aborted by start withdrawal");
  a_start_priority: assert property (
    !en_dly.start |=> !infeed_pulse_reg && !drive_en_reg && !drive_pulse_reg)
    else $error("enable active while start inhibits");
  a_group_spread: assert property (
    $changed(infeed_pulse_reg) |-> $past(pulse_on) != $past(infeed_pulse_reg)
      && MODULE_PULSE_EN_O == INFEED_PULSE_EN_O)
    else $error("pulse enable not spread together");
  a_coast_down: assert property (
    !en_dly.pulse |=> !drive_pulse_reg && !braking_reg)
    else $error("braking while pulse enable withdrawn");
  a_unregulated: assert property (
    !infeed_pulse_reg |-> !DCLINK_REGULATED_O)
    else $error("DC link regulated with pulses inhibited");
  a_drive_spread: assert property (
    $rose(drive_en_reg) |-> $past(en_dly.drive) && $past(pulse_on))
    else $error("drive enable without delayed terminal");
  a_setpoint_zero: assert property (
    (drive_en_reg && !en_dly.drive) |=> SPEED_SET_ZERO_O)
    else $error("setpoint not forced to zero");
  a_brake_cancel: assert property (
    (braking_reg && brake_done) |=> !braking_reg ##1 !drive_pulse_reg)
    else $error("braking did not cancel pulses");
  a_regen_limit: assert property (
    (REG_WR_I && REG_ADDR_I == OFS_REGEN)
      |=> REGEN_LIMIT_O == $past(REG_WDATA_I[15:0]))
    else $error("regenerative limit not taken");

  c_reach_run: cover property (
    state_reg == IES_CHARGED ##1 state_reg == IES_RUN);
  c_shutdown: cover property (
    state_reg == IES_SHUT_CONTACT ##1 state_reg == IES_IDLE);
  c_brake_end: cover property (braking_reg ##1 !braking_reg && pulse_on);
  c_late_stop: cover property (state_reg == IES_PRECHARGE && !START_I);

endmodule

// >>> dv/ies_plc_model.sv
// Machine controller and power stage as seen from the infeed terminals.
`timescale 1ns/100ps
module ies_plc_model #(
  parameter int P_CHG_DLY = 40
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench.
  input wire logic want_start_i,
  input wire logic want_pulse_i,
  input wire logic want_drive_i,
  input wire logic want_coil_i,
  input wire logic hold_speed_i,
  input wire logic [15:0] speed_set_i,
  // Contactors and braking state from the device.
  input wire logic prechg_i,
  input wire logic line_i,
  input wire logic spd_zero_i,
  // Terminals and feedback towards the device.
  output logic start_o,
  output logic pulse_o,
  output logic drive_o,
  output logic coil_o,
  output logic charged_o,
  output logic [15:0] speed_o,
  // Disconnection seen on the contactor feedback.
  output logic discon_o
);
  int chg_cnt; // Cycles of pre-charge current so far.

  ////////////////////////////////////////////////////////////////////////////
  // Terminals follow the bench one cycle later, like PLC outputs.
  always_ff @(posedge clk_i) begin
    start_o <= want_start_i & ~rst_i;
    pulse_o <= want_pulse_i & ~rst_i;
    drive_o <= want_drive_i & ~rst_i;
    // The loop may open one cycle after the start terminal or later, never first.
    coil_o <= rst_i | want_coil_i | start_o;
  end

  // The DC link charges only while the pre-charge contactor is closed.
  always_ff @(posedge clk_i) begin
    if (rst_i || (!prechg_i && !line_i)) begin
      chg_cnt <= 0;
    end else if (prechg_i && chg_cnt < P_CHG_DLY) begin
      chg_cnt <= chg_cnt + 1;
    end
  end
  assign charged_o = (chg_cnt >= P_CHG_DLY);

  // Axes hold their set speed and lose one unit a cycle while the setpoint is forced to zero.
  always_ff @(posedge clk_i) begin
    if (rst_i || !spd_zero_i) begin
      speed_o <= speed_set_i;
    end else if (!hold_speed_i && speed_o != 16'h0000) begin
      speed_o <= speed_o - 16'h0001;
    end
  end

  // With the loop open, the feedback contact must show the line open.
  always_ff @(posedge clk_i) begin
    discon_o <= ~rst_i & ~coil_o & ~line_i;
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the infeed enable sequencer.
`timescale 1ns/100ps
module tb_top import ies_pkg::*;;
  localparam int P = 4; // Clock cycles per millisecond in this run.
  logic REF_CLK_I = 1'b0;
  logic SYS_RST_I, START_I, PULSE_EN_I, DRIVE_EN_I, DC_CHARGED_I;
  logic CONTACTOR_COIL_LOOP_CLOSED_I, REG_WR_I, REG_RD_I;
  logic [15:0] SPEED_I, DECEL_LIMIT_O, REGEN_LIMIT_O, speed_set;
  logic [7:0] REG_ADDR_I;
  logic [31:0] REG_WDATA_I, REG_RDATA_O;
  logic PRECHG_CONTACTOR_O, LINE_CONTACTOR_O, INT_ENABLE_O;
  logic INFEED_PULSE_EN_O, DCLINK_REGULATED_O, MODULE_PULSE_EN_O;
  logic DRIVE_PULSE_EN_O, DRIVE_ENABLE_O, SPEED_SET_ZERO_O, discon;
  logic want_start, want_pulse, want_drive, want_coil, hold_speed;
  logic [8:0] obs; // Watched levels, one bit each.
  logic [31:0] shadow [5]; // Register contents the model expects.
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 REF_CLK_I = ~REF_CLK_I;
  assign obs = {DC_CHARGED_I, DCLINK_REGULATED_O, SPEED_SET_ZERO_O,
    DRIVE_ENABLE_O, DRIVE_PULSE_EN_O, INFEED_PULSE_EN_O, INT_ENABLE_O,
    LINE_CONTACTOR_O, PRECHG_CONTACTOR_O};

  ies_top #(.P_MS_CYCLES(P)) i_ies_top (.REF_CLK_I(REF_CLK_I),
    .SYS_RST_I(SYS_RST_I), .START_I(START_I), .PULSE_EN_I(PULSE_EN_I),
    .DRIVE_EN_I(DRIVE_EN_I), .DC_CHARGED_I(DC_CHARGED_I),
    .CONTACTOR_COIL_LOOP_CLOSED_I(CONTACTOR_COIL_LOOP_CLOSED_I),
    .SPEED_I(SPEED_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .PRECHG_CONTACTOR_O(PRECHG_CONTACTOR_O),
    .LINE_CONTACTOR_O(LINE_CONTACTOR_O), .INT_ENABLE_O(INT_ENABLE_O),
    .INFEED_PULSE_EN_O(INFEED_PULSE_EN_O),
    .DCLINK_REGULATED_O(DCLINK_REGULATED_O),
    .MODULE_PULSE_EN_O(MODULE_PULSE_EN_O),
    .DRIVE_PULSE_EN_O(DRIVE_PULSE_EN_O), .DRIVE_ENABLE_O(DRIVE_ENABLE_O),
    .SPEED_SET_ZERO_O(SPEED_SET_ZERO_O), .DECEL_LIMIT_O(DECEL_LIMIT_O),
    .REGEN_LIMIT_O(REGEN_LIMIT_O));

  ies_plc_model i_ies_plc_model (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I),
    .want_start_i(want_start), .want_pulse_i(want_pulse),
    .want_drive_i(want_drive), .want_coil_i(want_coil),
    .hold_speed_i(hold_speed), .speed_set_i(speed_set),
    .prechg_i(PRECHG_CONTACTOR_O), .line_i(LINE_CONTACTOR_O),
    .spd_zero_i(SPEED_SET_ZERO_O), .start_o(START_I), .pulse_o(PULSE_EN_I),
    .drive_o(DRIVE_EN_I), .coil_o(CONTACTOR_COIL_LOOP_CLOSED_I),
    .charged_o(DC_CHARGED_I), .speed_o(SPEED_I), .discon_o(discon));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, reached from the sequence or the watchdog.
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Exact comparison of a sampled value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A measured delay must fall inside a window of cycles.
  task automatic rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  // Counts falling edges until a watched level takes a value.
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    while (obs[b] !== v && n < 20000) begin
      @(negedge REF_CLK_I);
      n++;
    end
  endtask

  // One-cycle write; the model mirrors mapped writable offsets.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'b0;
    if (a < 8'h14 && a[1:0] == 2'b00) begin
      shadow[a[4:2]] = {16'h0000, d[15:0]};
    end
  endtask

  // One-cycle read; data is taken in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'b0;
    @(negedge REF_CLK_I);
    d = REG_RDATA_O;
  endtask

  // Set a terminal request just after a rising edge, clear of its sampling.
  task automatic req(output logic s, input logic v);
    @(posedge REF_CLK_I);
    #1 s = v;
  endtask

  // Watchdog: the whole sequence needs well under this many cycles.
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int n;
    int m;
    int v;
    {REG_ADDR_I, REG_WDATA_I, REG_WR_I, REG_RD_I} = '0;
    {want_start, want_pulse, want_drive, hold_speed} = '0;
    want_coil = 1'b1;
    speed_set = 16'h0000;
    SYS_RST_I = 1'b1;
    shadow = '{{16'h0, RST_SPD_THR}, {16'h0, RST_BRK_TIME},
      {16'h0, RST_DROPOUT}, {16'h0, RST_DECEL}, {16'h0, RST_REGEN}};
    void'($urandom(32'hf7bf));
    repeat (20) @(posedge REF_CLK_I);
    SYS_RST_I <= 1'b0;
    // Reset values, random write-back, unmapped and read-only places.
    for (int i = 0; i < 5; i++) begin
      reg_rd(8'(i * 4), d);
      chk(d, shadow[i]);
    end
    reg_wr(OFS_DECEL, $urandom);
    reg_wr(OFS_REGEN, $urandom);
    reg_wr(OFS_STATUS, 32'hffff_ffff);
    reg_wr(OFS_SPD_THR, 32'h0000_0010);
    reg_wr(OFS_BRK_TIME, 32'h0000_0064);
    reg_wr(OFS_DROPOUT, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      reg_rd(8'(i * 4), d);
      chk(d, shadow[i]);
    end
    chk(DECEL_LIMIT_O, shadow[3][15:0]);
    chk(REGEN_LIMIT_O, shadow[4][15:0]);
    reg_rd(8'h18, d);
    chk(d, 32'h0);
    reg_rd(OFS_STATUS, d);
    chk(d, 32'h0);
    $display("registers done");
    // Start dropped while charging: charging finishes, then shutdown.
    req(want_start, 1'b1);
    wait_bit(0, 1'b1, n);
    rng(n, 1, 6);
    repeat (10) @(negedge REF_CLK_I);
    req(want_start, 1'b0);
    wait_bit(8, 1'b1, n);
    chk(PRECHG_CONTACTOR_O, 1'b1);
    chk(LINE_CONTACTOR_O, 1'b0);
    repeat (10 * P) @(negedge REF_CLK_I);
    reg_rd(OFS_STATUS, d);
    chk({d[ST_ISOL], d[ST_INTEN], d[2:0]}, 5'b10000);
    $display("start withdrawn during charge done");
    // Full power-up with pulses held off in standby.
    req(want_start, 1'b1);
    wait_bit(8, 1'b1, n);
    wait_bit(0, 1'b0, n);
    rng(n, 499 * P, 501 * P + 4);
    chk(LINE_CONTACTOR_O, 1'b1);
    wait_bit(2, 1'b1, m);
    rng(n + m, 999 * P, 1001 * P + 4);
    chk({INFEED_PULSE_EN_O, DCLINK_REGULATED_O}, 2'b00);
    req(want_pulse, 1'b1);
    wait_bit(3, 1'b1, n);
    rng(n, P - 1, P + 5);
    chk({MODULE_PULSE_EN_O, DCLINK_REGULATED_O}, 2'b11);
    $display("power-up done");
    // Drive braking that ends on the speed threshold.
    v = 32 + ($urandom % 64);
    speed_set <= 16'(v);
    req(want_drive, 1'b1);
    wait_bit(5, 1'b1, n);
    rng(n, P - 1, P + 5);
    chk({DRIVE_PULSE_EN_O, SPEED_SET_ZERO_O}, 2'b10);
    req(want_drive, 1'b0);
    wait_bit(6, 1'b1, n);
    rng(n, P - 1, P + 5);
    chk(DRIVE_PULSE_EN_O, 1'b1);
    wait_bit(4, 1'b0, n);
    rng(n, v - 19, v - 9);
    // Speed held high: braking ends when the 2 ms timer runs out.
    reg_wr(OFS_BRK_TIME, 32'h0000_0002);
    hold_speed <= 1'b1;
    req(want_drive, 1'b1);
    wait_bit(5, 1'b1, n);
    req(want_drive, 1'b0);
    wait_bit(6, 1'b1, n);
    wait_bit(4, 1'b0, n);
    rng(n, P - 2, 2 * P + 4);
    $display("drive braking done");
    // Pulse withdrawal with drive on: pulses go at once, drives coast.
    hold_speed <= 1'b0;
    req(want_drive, 1'b1);
    wait_bit(4, 1'b1, n);
    req(want_pulse, 1'b0);
    wait_bit(4, 1'b0, n);
    rng(n, P - 1, P + 5);
    chk({INFEED_PULSE_EN_O, DCLINK_REGULATED_O}, 2'b00);
    req(want_pulse, 1'b1);
    wait_bit(7, 1'b1, n);
    chk(INFEED_PULSE_EN_O, 1'b1);
    wait_bit(4, 1'b1, n);
    $display("pulse withdrawal done");
    // Shutdown with pulse and drive terminals still on.
    req(want_start, 1'b0);
    wait_bit(3, 1'b0, n);
    rng(n, P - 1, P + 5);
    chk({LINE_CONTACTOR_O, DRIVE_PULSE_EN_O}, 2'b10);
    wait_bit(1, 1'b0, n);
    rng(n, 0, 3);
    req(want_coil, 1'b0);
    repeat (6 * P) @(negedge REF_CLK_I);
    reg_rd(OFS_STATUS, d);
    chk({d[ST_ISOL], d[2:0]}, 4'b1000);
    chk(discon, 1'b1);
    $display("shutdown done");
    wrap_up();
  end
endmodule
